// [acfc_flow_control.sv]
/*
  Conversion flow control: one APB slave holding the request register and a config register,
  plus the sequencer that turns requests into a channel sample start.
  Assumes an APB master on core_clk, a conversion clock tick from the converter core (same
  clock domain, one-cycle pulse) and a read-bus grant from the command list fetch logic.
*/
// Design decision made here: the APB register port.
// Behaviour
// - Requests writable three bus clocks after enable
// - Enable clear or soft reset clears all
// - Request bits set only while enabled
// - Writing zero leaves bits unchanged
// - Restart loads first list command first
// - Restart mode: two bus plus two pump
// - Back to back, restart mode: five bus plus two pump
// - Trigger mode: restart also raises trigger
// - Restart time depends on read bus
// - Trigger mode: restart, trigger clear together
// - Trigger mode: five bus after trigger clears
`timescale 1ns/1ps
`default_nettype none
`include "acfc_regs.svh"

module acfc_flow_control (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter core
  input wire logic convTick,
  input wire logic convPeriodEnd,
  input wire logic seqActive,
  input wire logic readBusGrant,
  output logic loadFirstCommand,
  output logic sampleStart,
  output logic abortSequence,
  output logic listLoadOkPulse
);

  // Bus decode
  logic apbAccess;
  logic apbWrite;
  logic hitFlow;
  logic hitConfig;
  // Config state
  logic enable_reg;
  logic trigMode_reg;
  logic softRst;
  // Request bits
  logic abortReq_reg;
  logic trigReq_reg;
  logic restartReq_reg;
  logic loadOk_reg;
  logic [1:0] enLatency_reg;
  logic writeOpen;
  logic clearAll;
  // Sequencer
  acfc_pkg::acfc_state_t state_reg;
  logic [2:0] busCnt_reg;
  logic [1:0] pumpCnt_reg;
  logic restartDone;
  logic trigDone;
  logic b2bLaunch;

  // Bus decode notes:
  // The slave never stretches a transfer, so pready is a constant one
  // and every access completes in its first access cycle.
  // Only two words are decoded; any other address reports pslverr
  // and has no effect, which keeps a stray write from touching the requests.
  // Soft reset is a strobe taken from the config write itself, so it
  // clears the requests on the same edge that the write lands.
  // Trade-off: a mis-aimed write is visible only through pslverr.
  assign apbAccess = psel && penable;
  assign apbWrite = apbAccess && pwrite;
  assign hitFlow = (paddr == `ACFC_FLOW_CTRL_ADDR);
  assign hitConfig = (paddr == `ACFC_CONFIG_ADDR);
  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = apbAccess && !hitFlow && !hitConfig;
  assign softRst = apbWrite && hitConfig && pwdata[`ACFC_CFG_SOFTRST];
  assign clearAll = !enable_reg || softRst;
  assign writeOpen = enable_reg && (enLatency_reg == 2'(`ACFC_EN_LATENCY));

  // Config register; soft reset is a self-clearing strobe, never stored
  always_ff @(posedge core_clk) begin
    if (rst) begin
      enable_reg <= 1'b0;
      trigMode_reg <= 1'b0;
    end else if (apbWrite && hitConfig) begin
      enable_reg <= pwdata[`ACFC_CFG_ENABLE];
      trigMode_reg <= pwdata[`ACFC_CFG_TRIGMODE];
    end
  end

  // The write window opens on the third bus clock after enable rises.
  // The counter restarts whenever enable falls, including a disable
  // that lands while it is still counting.
  // Enable latency counter: saturates after three bus clocks
  always_ff @(posedge core_clk) begin
    if (rst || !enable_reg) begin
      enLatency_reg <= 2'h0;
    end else if (enLatency_reg != 2'(`ACFC_EN_LATENCY)) begin
      enLatency_reg <= enLatency_reg + 2'h1;
    end
  end

  // Each request bit has its own set and clear terms.
  // A set from software wins over a completion in the same cycle,
  // so a fresh request is never swallowed by the tail of the old one.
  // Limitation: software must write whole values; a bit-level
  // read-modify-write would re-set any request still pending.
  // Clear by enable-off or soft reset beats everything else.
  // Request bits: write one sets, zero ignored, hardware clears on completion; set beats clear
  always_ff @(posedge core_clk) begin
    if (rst || clearAll) begin
      abortReq_reg <= 1'b0;
      trigReq_reg <= 1'b0;
      restartReq_reg <= 1'b0;
      loadOk_reg <= 1'b0;
    end else begin
      // Abort and load-ok are consumed the cycle after being seen
      if (apbWrite && hitFlow && writeOpen && pwdata[`ACFC_BIT_ABORT]) begin
        abortReq_reg <= 1'b1;
      end else if (abortReq_reg) begin
        abortReq_reg <= 1'b0;
      end
      if (apbWrite && hitFlow && writeOpen && pwdata[`ACFC_BIT_LOADOK]) begin
        loadOk_reg <= 1'b1;
      end else if (loadOk_reg) begin
        loadOk_reg <= 1'b0;
      end
      // In trigger mode a restart raises the trigger with it
      if (apbWrite && hitFlow && writeOpen && (pwdata[`ACFC_BIT_CONVERSION_TRIGGER_REQUEST]
          || (trigMode_reg && pwdata[`ACFC_BIT_RESTART]))) begin
        trigReq_reg <= 1'b1;
      end else if (trigDone) begin
        trigReq_reg <= 1'b0;
      end
      if (apbWrite && hitFlow && writeOpen && pwdata[`ACFC_BIT_RESTART]) begin
        restartReq_reg <= 1'b1;
      end else if (restartDone) begin
        restartReq_reg <= 1'b0;
      end
    end
  end

  // Read data is loaded in the setup cycle, so it shows the request bits
  // as they stand one cycle before the access phase completes.
  // A request that completes in that very cycle still reads as set.
  // Read data: live request state, upper bits zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == `ACFC_FLOW_CTRL_ADDR) begin
        prdata <= {24'h000000, abortReq_reg, trigReq_reg, restartReq_reg, loadOk_reg, 4'h0};
      end else if (paddr == `ACFC_CONFIG_ADDR) begin
        prdata <= {30'h0, trigMode_reg, enable_reg};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // Restart finishes when the list fetch gets the read bus; in trigger mode the trigger finishes in that same cycle, else from IDLE
  assign restartDone = (state_reg == acfc_pkg::ACFC_RESTART) && readBusGrant;
  assign trigDone = trigMode_reg ? restartDone
                                 : ((state_reg == acfc_pkg::ACFC_IDLE) && trigReq_reg && !restartReq_reg);
  assign b2bLaunch = (state_reg == acfc_pkg::ACFC_IDLE) && seqActive && convPeriodEnd;

  // Sequencer overview:
  // IDLE waits for a restart, a trigger or a back-to-back period end.
  // RESTART holds until the list fetch owns the read bus, so its length
  // varies with bus traffic and nothing here bounds it.
  // BUSWAIT counts bus clocks down to zero, one state per clock.
  // PUMP counts conversion clock ticks; a tick may be rare, so the
  // wait in this state is measured in ticks rather than bus clocks.
  // SAMPLE lasts one clock and is the only source of sampleStart.
  // An abort, a disable or a soft reset drops the sequencer to IDLE
  // from any state, which also discards a half-counted wait.
  // Hazard: in restart mode a trigger written while busy is kept pending and acted on
  // once the sequencer is back in IDLE.
  // Sampling launch sequencer
  always_ff @(posedge core_clk) begin
    if (rst || clearAll || abortReq_reg) begin
      state_reg <= acfc_pkg::ACFC_IDLE;
      busCnt_reg <= 3'h0;
      pumpCnt_reg <= 2'h0;
    end else begin
      case (state_reg)
        acfc_pkg::ACFC_IDLE: begin
          if (restartReq_reg) begin
            state_reg <= acfc_pkg::ACFC_RESTART;
          end else if (trigDone) begin
            state_reg <= acfc_pkg::ACFC_BUSWAIT;
            busCnt_reg <= 3'(`ACFC_RESTART_MODE_BUS - 1);
          end else if (b2bLaunch) begin
            state_reg <= acfc_pkg::ACFC_BUSWAIT;
            busCnt_reg <= 3'(`ACFC_B2B_BUS - 1);
          end
        end
        acfc_pkg::ACFC_RESTART: begin
          if (restartDone) begin
            if (trigMode_reg) begin
              state_reg <= acfc_pkg::ACFC_BUSWAIT;
              busCnt_reg <= 3'(`ACFC_CONVERSION_TRIGGER_REQUEST_MODE_BUS - 1);
            end else begin
              state_reg <= acfc_pkg::ACFC_IDLE;
            end
          end
        end
        acfc_pkg::ACFC_BUSWAIT: begin
          if (busCnt_reg == 3'h0) begin
            // Trigger mode needs no pump wait beyond its five bus clocks
            state_reg <= trigMode_reg ? acfc_pkg::ACFC_SAMPLE : acfc_pkg::ACFC_PUMP;
            pumpCnt_reg <= 2'(`ACFC_PUMP_CONV);
          end else begin
            busCnt_reg <= busCnt_reg - 3'h1;
          end
        end
        acfc_pkg::ACFC_PUMP: begin
          if (convTick) begin
            if (pumpCnt_reg == 2'h1) begin
              state_reg <= acfc_pkg::ACFC_SAMPLE;
            end
            pumpCnt_reg <= pumpCnt_reg - 2'h1;
          end
        end
        acfc_pkg::ACFC_SAMPLE: begin
          state_reg <= acfc_pkg::ACFC_IDLE;
        end
        default: begin
          state_reg <= acfc_pkg::ACFC_IDLE;
        end
      endcase
    end
  end

  // All four outputs are single-cycle pulses or levels from registers,
  // except loadFirstCommand, which follows the read-bus grant directly
  // so the list fetch can start in the cycle it gets the bus.
  // Outputs to the converter core
  assign loadFirstCommand = restartDone;
  assign sampleStart = (state_reg == acfc_pkg::ACFC_SAMPLE);
  assign abortSequence = abortReq_reg;
  assign listLoadOkPulse = loadOk_reg;

  // Assertions
  // These watch only state that this block drives.
  // Those that time the sequencer are switched off across an abort,
  // a disable or a soft reset, since each of these ends a wait early.
  // Trigger mode latency is counted from the cycle in which the restart
  // finishes; restart mode latency from the cycle the trigger is seen.
  // The pump phase depends on the converter's tick, so the timing
  // checks stop at the pump entry where the tick rate is not known.
  property p_lat;
    @(posedge core_clk) disable iff (rst)
    $rose(enable_reg) |-> !writeOpen [*3] ##1 writeOpen || !enable_reg;
  endproperty
  a_lat: assert property (p_lat) else $error("write window opened early");

  property p_clr;
    @(posedge core_clk) disable iff (rst)
    clearAll |=> !abortReq_reg && !trigReq_reg && !restartReq_reg && !loadOk_reg;
  endproperty
  a_clr: assert property (p_clr) else $error("requests not cleared");

  property p_noset;
    @(posedge core_clk) disable iff (rst)
    !enable_reg |=> !trigReq_reg;
  endproperty
  a_noset: assert property (p_noset) else $error("trigger set while disabled");

  property p_zero;
    @(posedge core_clk) disable iff (rst)
    restartReq_reg && !restartDone && !clearAll |=> restartReq_reg;
  endproperty
  a_zero: assert property (p_zero) else $error("restart lost without completion");

  property p_tm;
    @(posedge core_clk) disable iff (rst)
    trigMode_reg && writeOpen && apbWrite && hitFlow && pwdata[`ACFC_BIT_RESTART] |=> trigReq_reg;
  endproperty
  a_tm: assert property (p_tm) else $error("restart did not raise trigger");

  property p_both;
    @(posedge core_clk) disable iff (rst)
    trigMode_reg && restartDone && !clearAll && !abortReq_reg |=> !restartReq_reg && !trigReq_reg
      ##0 state_reg == acfc_pkg::ACFC_BUSWAIT;
  endproperty
  a_both: assert property (p_both) else $error("restart and trigger not cleared together");

  property p_five;
    @(posedge core_clk) disable iff (rst || clearAll || abortReq_reg)
    trigMode_reg && restartDone |-> ##6 sampleStart;
  endproperty
  a_five: assert property (p_five) else $error("trigger mode sample late");

  property p_rm;
    @(posedge core_clk) disable iff (rst || clearAll || abortReq_reg)
    !trigMode_reg && trigDone |-> ##3 state_reg == acfc_pkg::ACFC_PUMP;
  endproperty
  a_rm: assert property (p_rm) else $error("restart mode bus wait wrong");

  c_restart: cover property (@(posedge core_clk) restartDone);
  c_sample: cover property (@(posedge core_clk) sampleStart);
  // Back-to-back launch spends five bus clocks in the wait state
  property p_b2b;
    @(posedge core_clk) disable iff (rst || clearAll || abortReq_reg)
    !trigMode_reg && b2bLaunch && !trigReq_reg && !restartReq_reg |=> state_reg == acfc_pkg::ACFC_BUSWAIT
      ##4 state_reg == acfc_pkg::ACFC_BUSWAIT ##1 state_reg == acfc_pkg::ACFC_PUMP;
  endproperty
  a_b2b: assert property (p_b2b) else $error("back to back bus wait wrong");

  // Restart stays in progress until the read bus is granted
  property p_wait;
    @(posedge core_clk) disable iff (rst || clearAll || abortReq_reg)
    state_reg == acfc_pkg::ACFC_RESTART && !readBusGrant |=> state_reg == acfc_pkg::ACFC_RESTART;
  endproperty
  a_wait: assert property (p_wait) else $error("restart finished without read bus");

  // Read data in the access phase shows the request bits of the setup cycle
  property p_rd;
    @(posedge core_clk) disable iff (rst)
    psel && !penable && !pwrite && hitFlow |=> prdata[`ACFC_BIT_ABORT] == $past(abortReq_reg)
      && prdata[`ACFC_BIT_CONVERSION_TRIGGER_REQUEST] == $past(trigReq_reg) && prdata[`ACFC_BIT_RESTART] == $past(restartReq_reg)
      && prdata[`ACFC_BIT_LOADOK] == $past(loadOk_reg);
  endproperty
  a_rd: assert property (p_rd) else $error("read data does not show request bits");

  c_b2b: cover property (@(posedge core_clk) b2bLaunch);
  c_trigmode: cover property (@(posedge core_clk) trigMode_reg && restartDone);
  c_abort: cover property (@(posedge core_clk) abortSequence);

endmodule : acfc_flow_control
`default_nettype wire

// [acfc_regs.svh]
/*
  Register offsets, bit positions and timing counts for the conversion flow control block.
  Assumes inclusion by acfc_flow_control.sv and the testbench, not by acfc_pkg.sv; definitions only.
*/
`ifndef ACFC_REGS_SVH
`define ACFC_REGS_SVH

// Register index as printed, byte address is four times it
`define ACFC_FLOW_CTRL_IDX 8'h05
`define ACFC_FLOW_CTRL_ADDR 12'h014
// Enable and mode register (block-local)
`define ACFC_CONFIG_ADDR 12'h020
// Request bit positions in conversion_flow_control
`define ACFC_BIT_ABORT 7
`define ACFC_BIT_CONVERSION_TRIGGER_REQUEST 6
`define ACFC_BIT_RESTART 5
`define ACFC_BIT_LOADOK 4
// Config bit positions
`define ACFC_CFG_ENABLE 0
`define ACFC_CFG_TRIGMODE 1
`define ACFC_CFG_SOFTRST 2
// Reset values
`define ACFC_FLOW_RESET 8'h00
`define ACFC_CONFIG_RESET 8'h00
// Timing counts in bus clocks, except the pump count in conversion ticks
`define ACFC_EN_LATENCY 3
`define ACFC_RESTART_MODE_BUS 2
`define ACFC_B2B_BUS 5
`define ACFC_CONVERSION_TRIGGER_REQUEST_MODE_BUS 5
`define ACFC_PUMP_CONV 2

`endif

// [acfc_pkg.sv]
/*
  Types for the conversion flow control block.
  Assumes the register header is compiled alongside.
*/
package acfc_pkg;
  // Sampling launch sequencer states
  typedef enum logic [2:0] {
    ACFC_IDLE,
    ACFC_RESTART,
    ACFC_BUSWAIT,
    ACFC_PUMP,
    ACFC_SAMPLE
  } acfc_state_t;
endpackage : acfc_pkg

// [tb_adc_conversion_flow_control.sv]
/*
  Self-checking testbench for the conversion flow control block: APB tasks and directed sequences.
  Assumes the register header and the design file are compiled first; single 200 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "acfc_regs.svh"

module tb_adc_conversion_flow_control;
  // APB side
  logic core_clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  // Converter core side
  logic convTick, convPeriodEnd, seqActive, readBusGrant;
  logic loadFirstCommand, sampleStart, abortSequence, listLoadOkPulse;
  // Monitor state: check counters, cycle stamps and pulse flags
  int mismatches = 0, checked = 0, cyc = 0, wrCyc, lfcCyc, sCyc, cpeCyc;
  logic sSeen, abSeen, lokSeen;

  acfc_flow_control dut (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .convTick(convTick), .convPeriodEnd(convPeriodEnd), .seqActive(seqActive),
    .readBusGrant(readBusGrant), .loadFirstCommand(loadFirstCommand), .sampleStart(sampleStart),
    .abortSequence(abortSequence), .listLoadOkPulse(listLoadOkPulse)
  );

  // Clock, 5 ns period
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // Verdict and end of run
  task automatic wrap_up();
    if (mismatches == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  // Compare a register or flag value
  task automatic checkWord(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : checkWord

  // Compare a measured latency against a window
  task automatic checkRange(input int got, input int lo, input int hi);
    checked++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : checkRange

  // Pulse catcher; the timeout is generous since the whole run is under two hundred cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (sampleStart === 1'b1) begin
      sSeen = 1'b1;
      sCyc = cyc;
    end
    if (loadFirstCommand === 1'b1) lfcCyc = cyc;
    if (convPeriodEnd === 1'b1) cpeCyc = cyc;
    if (abortSequence === 1'b1) abSeen = 1'b1;
    if (listLoadOkPulse === 1'b1) lokSeen = 1'b1;
    if (cyc > 3000) begin
      mismatches++;
      wrap_up();
    end
  end

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    wrCyc = cyc;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Bounded wait for a sample start, which must come
  task automatic waitSample();
    repeat (40) begin
      if (!sSeen) @(posedge core_clk);
    end
    checkWord(sSeen, 1);
  endtask : waitSample

  // Main sequence
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    convTick = 1'b1;
    convPeriodEnd = 1'b0;
    seqActive = 1'b0;
    readBusGrant = 1'b0;
    sSeen = 1'b0;
    abSeen = 1'b0;
    lokSeen = 1'b0;
    rst = 1'b1;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    apb(1'b0, `ACFC_FLOW_CTRL_ADDR, 32'h0);
    checkWord(rd, `ACFC_FLOW_RESET);
    apb(1'b0, `ACFC_CONFIG_ADDR, 32'h0);
    checkWord(rd, `ACFC_CONFIG_RESET);
    // Disabled: every set attempt is dropped
    apb(1'b1, `ACFC_FLOW_CTRL_ADDR, 32'h000000F0);
    apb(1'b0, `ACFC_FLOW_CTRL_ADDR, 32'h0);
    checkWord(rd, 32'h0);
    checkWord(abSeen, 0);
    // Enable in trigger mode; a restart written at once falls inside the latency
    apb(1'b1, `ACFC_CONFIG_ADDR, 32'h3);
    apb(1'b1, `ACFC_FLOW_CTRL_ADDR, 32'h20);
    apb(1'b0, `ACFC_FLOW_CTRL_ADDR, 32'h0);
    checkWord(rd, 32'h0);
    // Restart held pending by a busy read bus; trigger rises with it
    apb(1'b1, `ACFC_FLOW_CTRL_ADDR, 32'h20);
    apb(1'b0, `ACFC_FLOW_CTRL_ADDR, 32'h0);
    checkWord(rd, 32'h60);
    apb(1'b1, `ACFC_FLOW_CTRL_ADDR, 32'h0);
    apb(1'b0, `ACFC_FLOW_CTRL_ADDR, 32'h0);
    checkWord(rd, 32'h60);
    sSeen = 1'b0;
    readBusGrant <= 1'b1;
    waitSample();
    checkRange(sCyc - lfcCyc, 6, 6);
    apb(1'b0, `ACFC_FLOW_CTRL_ADDR, 32'h0);
    checkWord(rd, 32'h0);
    readBusGrant <= 1'b0;
    // Restart mode trigger from idle
    apb(1'b1, `ACFC_CONFIG_ADDR, 32'h1);
    sSeen = 1'b0;
    apb(1'b1, `ACFC_FLOW_CTRL_ADDR, 32'h40);
    waitSample();
    checkRange(sCyc - wrCyc, 4, 6);
    // Abort and load-ok together in one whole-value write
    apb(1'b1, `ACFC_FLOW_CTRL_ADDR, 32'h90);
    repeat (3) @(posedge core_clk);
    checkWord(abSeen, 1);
    checkWord(lokSeen, 1);
    // Back-to-back launch from a conversion period end
    seqActive <= 1'b1;
    sSeen = 1'b0;
    @(posedge core_clk);
    convPeriodEnd <= 1'b1;
    @(posedge core_clk);
    convPeriodEnd <= 1'b0;
    waitSample();
    checkRange(sCyc - cpeCyc, 7, 9);
    seqActive <= 1'b0;
    // Soft reset, then disable, each wipe a pending restart
    apb(1'b1, `ACFC_CONFIG_ADDR, 32'h3);
    repeat (4) @(posedge core_clk);
    apb(1'b1, `ACFC_FLOW_CTRL_ADDR, 32'h20);
    apb(1'b1, `ACFC_CONFIG_ADDR, 32'h7);
    apb(1'b0, `ACFC_FLOW_CTRL_ADDR, 32'h0);
    checkWord(rd, 32'h0);
    repeat (4) @(posedge core_clk);
    apb(1'b1, `ACFC_FLOW_CTRL_ADDR, 32'h20);
    apb(1'b1, `ACFC_CONFIG_ADDR, 32'h0);
    apb(1'b0, `ACFC_FLOW_CTRL_ADDR, 32'h0);
    checkWord(rd, 32'h0);
    // Unmapped address answers with an error and zero data
    apb(1'b0, 12'h0FC, 32'h0);
    checkWord(err, 1);
    checkWord(rd, 32'h0);
    wrap_up();
  end
endmodule : tb_adc_conversion_flow_control

`default_nettype wire
